// File: verilog/read_boundary_split.sv
// Downstream read path that cuts reads at 1 MB boundaries and returns split completions.
`timescale 1ns/1ps
module read_boundary_split (
  input  wire logic                           ref_clk,       // Bridge clock, 50 MHz.
  input  wire logic                           rst,           // Synchronous reset, active high.
  input  wire logic                           req_valid,     // Read request offered.
  input  wire read_split_pkg::read_req_t      req,           // Read request fields.
  output logic                                req_ready,     // Request taken when high with valid.
  output logic                                bus_cmd_valid, // Conventional-bus read to issue.
  output read_split_pkg::bus_cmd_t            bus_cmd,       // Issued address and doubleword count.
  input  wire logic                           bus_cmd_ready, // Bus transaction started.
  input  wire logic                           bus_data_valid, // Read data phase from the target.
  input  wire logic [31:0]                    bus_data,      // Read data.
  output logic                                bus_data_ready, // Data phase may complete.
  output logic                                bus_stop,      // Disconnect after this data phase.
  output logic                                cpl_valid,     // Completion beat valid.
  output read_split_pkg::cpl_beat_t           cpl,           // Completion beat.
  input  wire logic                           cpl_ready,     // Completion beat accepted.
  output logic                                buf_release,   // One-cycle buffer release pulse.
  output logic [read_split_pkg::DW_W-1:0]     buf_release_dw // Doublewords released.
);
  import read_split_pkg::*;

  state_t            state;
  logic              seg_second;
  logic              seg_bcm;
  logic [ADDR_W-1:0] seg_addr;
  logic [BC_W-1:0]   seg_bytes;
  logic [BC_W-1:0]   rest_bytes;
  logic [DW_W-1:0]   seg_dw;
  logic [DW_W-1:0]   taken_dw;
  logic              out_valid;
  cpl_beat_t         out_beat;

  logic [BC_W-1:0]   total_bytes;
  logic [BND_LSB:0]  to_bnd;
  logic              crosses;
  logic [BC_W-1:0]   first_bytes;
  logic              take_beat;
  logic              last_take;
  logic              last_sent;
  logic              load_first;
  logic              load_second;

  function automatic logic [DW_W-1:0] dword_span(input logic [1:0] lo, input logic [BC_W-1:0] bytes);
    logic [BC_W+1:0] sum;
    sum = {{BC_W{1'b0}}, lo} + {2'h0, bytes} + DW_ROUND;
    // The top bits are always zero, since a segment never spans more than 4096 bytes.
    return sum[DW_W+1:2];
  endfunction

  always_comb begin
    total_bytes = req.burst ? ((req.byte_count == BC_ZERO) ? MAX_BYTES : {1'b0, req.byte_count})
                            : {1'b0, req.byte_count};
    // True byte distance to the next boundary, so starts 9 to 11 bytes out are caught.
    to_bnd = BND_SIZE - {1'b0, req.addr[BND_LSB-1:0]};
    // A non-burst read is one doubleword and never split.
    crosses = req.burst && ({{(BND_LSB+1-BC_W){1'b0}}, total_bytes} > to_bnd);
    first_bytes = crosses ? to_bnd[BC_W-1:0] : total_bytes;
  end

  assign req_ready     = (state == ST_IDLE);
  assign bus_cmd_valid = (state == ST_ISSUE);
  assign take_beat     = (state == ST_XFER) && bus_data_valid && bus_data_ready;
  assign last_take     = take_beat && (taken_dw + DW_ONE == seg_dw);
  assign last_sent     = out_valid && cpl_ready && out_beat.last;
  assign load_first    = (state == ST_IDLE) && req_valid;
  assign load_second   = (state == ST_RELEASE) && !seg_second && (rest_bytes != BYTES_NONE);

  always_comb begin
    bus_cmd.addr   = {seg_addr[ADDR_W-1:2], LOW_ZERO};
    bus_cmd.dwords = seg_dw;
    bus_cmd.burst  = seg_bcm | seg_second | (seg_dw != DW_ONE);
    bus_data_ready = (state == ST_XFER) && (taken_dw != seg_dw) && (!out_valid || cpl_ready);
    bus_stop       = last_take;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (req_valid) begin
            state <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (bus_cmd_ready) begin
            state <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (last_sent) begin
            state <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          // Reissue only for bytes beyond the boundary of a crossing burst.
          if (load_second) begin
            state <= ST_ISSUE;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // The first segment loads from the request, the second from what is left past the boundary.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seg_second <= 1'b0;
      seg_bcm    <= 1'b0;
    end else if (load_first) begin
      seg_second <= 1'b0;
      seg_bcm    <= crosses;
    end else if (load_second) begin
      seg_second <= 1'b1;
      seg_bcm    <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seg_addr <= '0;
    end else if (load_first) begin
      seg_addr <= req.addr;
    end else if (load_second) begin
      seg_addr <= {seg_addr[ADDR_W-1:BND_LSB] + 12'h001, BND_ZERO};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seg_bytes  <= BYTES_NONE;
      rest_bytes <= BYTES_NONE;
    end else if (load_first) begin
      seg_bytes  <= first_bytes;
      rest_bytes <= total_bytes - first_bytes;
    end else if (load_second) begin
      seg_bytes  <= rest_bytes;
      rest_bytes <= BYTES_NONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seg_dw <= DW_NONE;
    end else if (load_first) begin
      seg_dw <= dword_span(req.addr[1:0], first_bytes);
    end else if (load_second) begin
      seg_dw <= dword_span(LOW_ZERO, rest_bytes);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      taken_dw <= DW_NONE;
    end else if (state == ST_ISSUE) begin
      taken_dw <= DW_NONE;
    end else if (take_beat) begin
      taken_dw <= taken_dw + DW_ONE;
    end
  end

  // Single output register; its ready term stalls the bus data phases.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_valid <= 1'b0;
    end else if (take_beat) begin
      out_valid <= 1'b1;
    end else if (cpl_ready) begin
      out_valid <= 1'b0;
    end
  end

  // The beat keeps its fields while the requester stalls the completion.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_beat <= '0;
    end else if (take_beat) begin
      out_beat.data       <= bus_data;
      out_beat.start_addr <= seg_addr;
      out_beat.byte_count <= seg_bytes;
      out_beat.bcm        <= seg_bcm;
      out_beat.first      <= (taken_dw == DW_NONE);
      out_beat.last       <= last_take;
    end
  end

  assign cpl_valid = out_valid;
  assign cpl       = out_beat;

  // Frees exactly the doublewords of the completion just sent.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      buf_release <= 1'b0;
    end else begin
      buf_release <= last_sent;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      buf_release_dw <= DW_NONE;
    end else begin
      buf_release_dw <= last_sent ? seg_dw : DW_NONE;
    end
  end
endmodule

// File: verilog/read_split_pkg.sv
// Shared types and constants for the downstream read boundary splitter.
package read_split_pkg;
  localparam int ADDR_W = 32;
  localparam int BC_W   = 13;
  localparam int DW_W   = 11;
  localparam int BND_LSB = 20;

  localparam logic [BND_LSB:0]    BND_SIZE  = 21'h100000;
  localparam logic [BC_W-1:0]     MAX_BYTES = 13'h1000;
  localparam logic [11:0]         BC_ZERO   = 12'h000;
  localparam logic [1:0]          LOW_ZERO  = 2'h0;
  localparam logic [BND_LSB-1:0]  BND_ZERO  = 20'h00000;
  localparam logic [BC_W+1:0]     DW_ROUND  = 15'h0003;
  localparam logic [DW_W-1:0]     DW_ONE    = 11'h001;
  localparam logic [DW_W-1:0]     DW_NONE   = 11'h000;
  localparam logic [BC_W-1:0]     BYTES_NONE = 13'h0000;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_ISSUE   = 2'h1,
    ST_XFER    = 2'h3,
    ST_RELEASE = 2'h2
  } state_t;

  // Read request from the split-transaction side; byte_count 0 means 4096 on a burst read.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [11:0]       byte_count;
    logic              burst;
  } read_req_t;

  // Read issued on the conventional bus.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DW_W-1:0]   dwords;
    logic              burst;
  } bus_cmd_t;

  // One data beat of a split completion.
  typedef struct packed {
    logic [31:0]       data;
    logic [ADDR_W-1:0] start_addr;
    logic [BC_W-1:0]   byte_count;
    logic              bcm;
    logic              first;
    logic              last;
  } cpl_beat_t;
endpackage

// File: dv/read_split_properties.sv
// Port-level checker for the read boundary splitter.
`timescale 1ns/1ps
module read_split_properties import read_split_pkg::*; (
  input wire logic        ref_clk,        // Bridge clock.
  input wire logic        rst,            // Synchronous reset.
  input wire logic        req_valid,      // Request offered.
  input wire logic        req_ready,      // Request taken.
  input wire logic        bus_cmd_valid,  // Read issued.
  input wire logic        bus_cmd_ready,  // Transaction started.
  input wire logic        bus_data_valid, // Data phase offered.
  input wire logic        bus_data_ready, // Data phase accepted.
  input wire logic        bus_stop,       // Disconnect.
  input wire logic        cpl_valid,      // Completion beat valid.
  input wire logic        cpl_ready,      // Completion beat accepted.
  input wire logic        buf_release,    // Buffer release pulse.
  input wire read_req_t   req,            // Request fields.
  input wire bus_cmd_t    bus_cmd,        // Issued read.
  input wire logic [31:0] bus_data,       // Read data.
  input wire cpl_beat_t   cpl             // Completion beat.
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic b;
  always_ff @(posedge ref_clk) if (req_valid && req_ready) b <= req.burst;
  property p_low; bus_cmd_valid |-> bus_cmd.addr[1:0] == 2'h0; endproperty
  a_low: assert property (p_low) else $error("issued address not aligned");
  property p_stop; bus_stop |-> bus_data_valid && bus_data_ready ##1 !bus_data_ready; endproperty
  a_stop: assert property (p_stop) else $error("disconnect outside a taken phase");
  property p_bnd; cpl_valid && cpl.bcm |-> cpl.start_addr[19:0] + 21'(cpl.byte_count) == BND_SIZE; endproperty
  a_bnd: assert property (p_bnd) else $error("modified count misses boundary");
  property p_nbcm; cpl_valid && !b |-> !cpl.bcm; endproperty
  a_nbcm: assert property (p_nbcm) else $error("modified flag on single read");
  property p_one; bus_cmd_valid && !b |-> bus_cmd.dwords == DW_ONE; endproperty
  a_one: assert property (p_one) else $error("single read not one dword");
  property p_rel; buf_release |-> $past(cpl_valid && cpl_ready && cpl.last); endproperty
  a_rel: assert property (p_rel) else $error("release without finished completion");
  property p_cpl; bus_data_valid && bus_data_ready |=> cpl_valid && cpl.data == $past(bus_data); endproperty
  a_cpl: assert property (p_cpl) else $error("completion data differs");
  property p_hold; cpl_valid && !cpl_ready |=> cpl_valid && $stable(cpl); endproperty
  a_hold: assert property (p_hold) else $error("completion beat changed while stalled");
  c_bcm: cover property (cpl_valid && cpl.bcm);
  c_stall: cover property (cpl_valid && !cpl_ready);
  c_rel: cover property (buf_release);
endmodule
bind read_boundary_split read_split_properties i_read_split_properties(.*);

// File: dv/pci_target_model.sv
// Target model answering issued reads with the dword address as data.
`timescale 1ns/1ps
module pci_target_model import read_split_pkg::*; (
  input  wire logic     ref_clk,        // Bridge clock.
  input  wire logic     rst,            // Synchronous reset.
  input  wire logic     slow,           // Insert wait states.
  input  wire logic     bus_cmd_valid,  // Read issued.
  input  wire bus_cmd_t bus_cmd,        // Issued read.
  output logic          bus_cmd_ready,  // Transaction started.
  output logic          bus_data_valid, // Data phase offered.
  output logic [31:0]   bus_data,       // Read data.
  input  wire logic     bus_data_ready, // Phase accepted.
  input  wire logic     bus_stop        // Disconnect.
);
  logic        act;
  logic        ph;
  logic [31:0] a;
  assign bus_cmd_ready  = bus_cmd_valid && !act && (!slow || ph);
  assign bus_data_valid = act && (!slow || ph);
  // Outside a data phase the line shows the inverse, so stale data never matches.
  assign bus_data       = bus_data_valid ? a : ~a;
  always_ff @(posedge ref_clk) ph <= rst ? 1'b0 : !ph;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      act <= 1'b0;
      a <= 32'h0;
    end else if (bus_cmd_valid && bus_cmd_ready) begin
      act <= 1'b1;
      a <= bus_cmd.addr;
    end else if (bus_data_valid && bus_data_ready) begin
      a <= a + 32'h4;
      act <= !bus_stop;
    end
  end
endmodule

// File: dv/testbench.sv
// Self-checking bench for the read boundary splitter.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module testbench;
  import read_split_pkg::*;
  logic ref_clk = 0, rst = 1, req_valid = 0, cpl_ready = 0, slow = 0;
  logic req_ready, bus_cmd_valid, bus_cmd_ready, bus_data_valid, bus_data_ready, bus_stop, cpl_valid, buf_release;
  read_req_t req = '0;
  bus_cmd_t bus_cmd;
  logic [31:0] bus_data, d0, dl;
  cpl_beat_t cpl;
  cpl_beat_t hd[2];
  logic [DW_W-1:0] buf_release_dw;
  int nc, nb, nt, rel, fail_count = 0, n_checks = 0, cyc = 0;
  always #10 ref_clk = ~ref_clk;
  read_boundary_split i_read_boundary_split(.*);
  pci_target_model i_pci_target_model(.*);
  task automatic results();
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin fail_count++; results(); end
  end
  // Issues one read and gathers completion headers, beats and released space.
  task automatic rd(input logic [31:0] ad, input logic [11:0] bc, input logic bu);
    req = '{ad, bc, bu};
    req_valid = 1;
    nc = 0; nb = 0; rel = 0;
    nt = 0;
    repeat (5000) begin
      @(posedge ref_clk); #1 req_valid = 0;
      cpl_ready = !slow || !cpl_ready;
      #17 rel += buf_release_dw;
      if (bus_cmd_valid && bus_cmd_ready) nt++;
      if (cpl_valid && cpl_ready) begin
        if (cpl.first) begin hd[nc] = cpl; nc++; end
        if (nb == 0) d0 = cpl.data;
        dl = cpl.data;
        nb++;
      end
      if (req_ready && nb > 0) break;
    end
    @(posedge ref_clk); #1;
  endtask
  task automatic t_near();
    for (int off = 9; off < 12; off++) begin
      rd(32'h100000 - off, 12'h00c, 1);
      `CHK(nc, 2)
      `CHK(nt, 2)
      `CHK(hd[0].byte_count, 13'(off))
      `CHK(hd[0].bcm, 1'b1)
      `CHK(hd[1].start_addr, 32'h100000)
      `CHK(hd[1].byte_count, 13'(12 - off))
      `CHK(nb, 4)
      `CHK(rel, 4)
      `CHK(d0, 32'hffff4)
    end
  endtask
  task automatic t_align();
    rd(32'hffff8, 12'h010, 1);
    `CHK({hd[0].byte_count, hd[0].bcm, hd[1].byte_count, hd[1].bcm}, {13'h8, 1'b1, 13'h8, 1'b0})
    `CHK(dl, 32'h100004)
  endtask
  task automatic t_onside();
    rd(32'h123401, 12'h008, 1);
    `CHK({nc, nb, hd[0].byte_count, hd[0].bcm}, {32'h1, 32'h3, 13'h8, 1'b0})
    `CHK(nt, 1)
  endtask
  task automatic t_dword();
    rd(32'hfffff, 12'h001, 0);
    `CHK({nc, nb, rel}, {32'h1, 32'h1, 32'h1})
    `CHK(nt, 1)
    `CHK(hd[0].bcm, 1'b0)
    `CHK({hd[0].byte_count, d0}, {13'h1, 32'hffffc})
  endtask
  task automatic t_4k();
    slow = 1;
    rd(32'hffffd, 12'h000, 1);
    `CHK({hd[0].byte_count, hd[0].bcm}, {13'h3, 1'b1})
    `CHK(hd[1].byte_count, 13'hffd)
    `CHK({nb, rel}, {32'h401, 32'h401})
    `CHK(nt, 2)
    slow = 0;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rst = 0;
    t_near();
    t_align();
    t_onside();
    t_dword();
    t_4k();
    results();
  end
endmodule
